// file: hdl/cks_pkg.sv
`default_nettype none
package cks_pkg;
  localparam int          ADDR_W            = 19;
  // Register indices; the byte address is four times the index
  localparam logic [16:0] IDX_SAMPLE_RATE   = 17'h04e20;
  localparam logic [16:0] IDX_CHANNELS      = 17'h04e22;
  localparam logic [16:0] IDX_CLKOUT_ENABLE = 17'h04e8e;
  localparam logic [16:0] IDX_CLKOUT_FREQ   = 17'h04e8f;
  localparam logic [16:0] IDX_CLOCK_SOURCE  = 17'h04ee8;
  localparam logic [16:0] IDX_AVAIL_SOURCES = 17'h04ee9;
  // Source codes
  localparam logic [5:0]  CODE_PLL          = 6'h01;
  localparam logic [5:0]  CODE_Q1           = 6'h02;
  localparam logic [5:0]  CODE_Q2           = 6'h04;
  localparam logic [5:0]  CODE_INT_MASK     = 6'h07;
  localparam logic [5:0]  CODE_EXT_MASK     = 6'h38;
  localparam logic [5:0]  CODE_NONE         = 6'h00;
  // Rates in hertz
  localparam logic [31:0] RATE_MIN_HZ       = 32'h000003e8;
  localparam logic [31:0] FAST_MAX_HZ       = 32'h0bebc200;
  localparam logic [31:0] FAST_REDUCED_HZ   = 32'h05f5e100;
  localparam logic [31:0] SLOW_MAX_HZ       = 32'h02faf080;
  localparam logic [31:0] SECOND_OSC_HZ_DEF = 32'h04c4b400;
  localparam logic [31:0] RATE_RESET_HZ     = 32'h00989680;
  localparam logic [31:0] ZERO32            = 32'h00000000;
  localparam logic [31:0] ONE32             = 32'h00000001;
  // Channels
  localparam logic [3:0]  CH_ODD            = 4'ha;
  localparam logic [3:0]  CH_TWO            = 4'h3;
  localparam logic [3:0]  CH_ALL            = 4'hf;
  localparam logic [3:0]  CH_RESET          = 4'h1;
  // Divider
  localparam logic [5:0]  DIV_STEPS         = 6'h20;
  localparam logic [5:0]  DIV_LAST          = 6'h01;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000001,
    ST_LAUNCH_N = 6'b000010,
    ST_WAIT_N   = 6'b000100,
    ST_LAUNCH_R = 6'b001000,
    ST_WAIT_R   = 6'b010000,
    ST_CHECK    = 6'b100000
  } cks_state_type;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [16:0] idx);
    return {idx, 2'h0};
  endfunction

  function automatic logic [31:0] max_rate(input logic fast, input logic [3:0] ch);
    if (!fast) begin
      return SLOW_MAX_HZ;
    end
    return ((ch & CH_ODD) != 4'h0) ? FAST_REDUCED_HZ : FAST_MAX_HZ;
  endfunction
endpackage
`default_nettype wire

// file: hdl/cks_div_if.sv
`default_nettype none
interface cks_div_if;
  logic        ce;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic [31:0] quotient;
  logic        done;
  modport client (output ce, start, dividend, divisor, input quotient, done);
  modport engine (input ce, start, dividend, divisor, output quotient, done);
endinterface
`default_nettype wire

// file: hdl/cks_divider.sv
`default_nettype none
module cks_divider
  import cks_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Operands and result
  cks_div_if.engine  port
);
  logic [31:0] rem;
  logic [31:0] quo;
  logic [31:0] dvs;
  logic [5:0]  steps;
  logic [32:0] shifted;
  logic        fits;

  // Restoring division, one quotient bit per cycle
  assign shifted      = {rem, quo[31]};
  assign fits         = shifted >= {1'h0, dvs};
  assign port.quotient = quo;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem       <= ZERO32;
      quo       <= ZERO32;
      dvs       <= ONE32;
      steps     <= 6'h00;
      port.done <= 1'h0;
    end else if (port.ce) begin
      port.done <= 1'h0;
      // A new start abandons any division in flight
      if (port.start) begin
        rem   <= ZERO32;
        quo   <= port.dividend;
        dvs   <= port.divisor;
        steps <= DIV_STEPS;
      end else if (steps != 6'h00) begin
        rem       <= fits ? 32'(shifted - {1'h0, dvs}) : shifted[31:0];
        quo       <= {quo[30:0], fits};
        steps     <= steps - DIV_LAST;
        port.done <= steps == DIV_LAST;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/cks_clock_select.sv
// Local design decisions: the address map and register access over APB.
`default_nettype none
module cks_clock_select
  import cks_pkg::*;
#(
  parameter logic [31:0] SECOND_OSC_HZ = SECOND_OSC_HZ_DEF
) (
  // Clock, reset, enable
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic              CLK_EN,
  // Board straps
  input  wire logic              FAST_VARIANT,
  input  wire logic              FOUR_CHANNELS,
  input  wire logic              SECOND_OSC_FITTED,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Clock generator control
  output logic      [5:0]        SOURCE_SELECT,
  output logic      [31:0]       DIVIDER,
  output logic      [31:0]       RATE_HZ,
  output logic      [3:0]        CHANNEL_ENABLE,
  output logic                   CLKOUT_DRIVE
);
  logic          rst_meta;
  logic          rst_n;
  logic          strap_taken;
  logic          fast;
  logic          four_ch;
  logic          q2_fitted;
  logic [5:0]    src_sel;
  logic [31:0]   request;
  logic          out_en;
  logic [3:0]    chan;
  logic          recalc;
  logic [31:0]   achieved;
  logic [31:0]   divider;
  logic [31:0]   div_n;
  logic [31:0]   rate_q;
  cks_state_type state;
  logic [5:0]    avail;
  logic [31:0]   rmax;
  logic [31:0]   clamped;
  logic [31:0]   osc_hz;
  logic [31:0]   clkout_freq;
  logic          is_quartz;
  logic          is_internal;
  logic          go;
  logic          too_fast;
  logic          too_slow;
  logic          hit_mode;
  logic          hit_avail;
  logic          hit_rate;
  logic          hit_oen;
  logic          hit_ofreq;
  logic          hit_chan;
  logic          unmapped;
  logic          mode_valid;
  logic          stall;
  logic          wr_done;
  cks_div_if     div ();

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  // Straps are caught once, after reset release
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'h0;
      fast        <= 1'h0;
      four_ch     <= 1'h0;
      q2_fitted   <= 1'h0;
    end else if (CLK_EN && !strap_taken) begin
      strap_taken <= 1'h1;
      fast        <= FAST_VARIANT;
      four_ch     <= FOUR_CHANNELS;
      q2_fitted   <= SECOND_OSC_FITTED;
    end
  end

  // Address decode
  assign hit_mode  = PADDR == reg_addr(IDX_CLOCK_SOURCE);
  assign hit_avail = PADDR == reg_addr(IDX_AVAIL_SOURCES);
  assign hit_rate  = PADDR == reg_addr(IDX_SAMPLE_RATE);
  assign hit_oen   = PADDR == reg_addr(IDX_CLKOUT_ENABLE);
  assign hit_ofreq = PADDR == reg_addr(IDX_CLKOUT_FREQ);
  assign hit_chan  = PADDR == reg_addr(IDX_CHANNELS);
  assign unmapped  = !(hit_mode | hit_avail | hit_rate | hit_oen | hit_ofreq | hit_chan);

  assign avail       = CODE_PLL | CODE_Q1 | (q2_fitted ? CODE_Q2 : CODE_NONE) | CODE_EXT_MASK;
  assign mode_valid  = $onehot(PWDATA[5:0]) && ((PWDATA[5:0] & avail) != CODE_NONE)
                       && (PWDATA[31:6] == 26'h0000000);
  assign is_internal = (src_sel & CODE_INT_MASK) != CODE_NONE;
  assign is_quartz   = (src_sel == CODE_Q1) || (src_sel == CODE_Q2);
  assign clkout_freq = (out_en && is_internal) ? achieved : ZERO32;

  // Reads of computed values wait until the new rate has settled
  assign stall   = !PWRITE && (hit_rate || hit_ofreq) && (recalc || state != ST_IDLE);
  assign PREADY  = CLK_EN && PSEL && PENABLE && !stall;
  assign PSLVERR = PREADY && (unmapped || (PWRITE && (hit_avail || hit_ofreq || (hit_mode && !mode_valid))));
  assign wr_done = PREADY && PWRITE && !PSLVERR;

  always_comb begin
    PRDATA = ZERO32;
    if (hit_mode) begin
      PRDATA = {26'h0000000, src_sel};
    end else if (hit_avail) begin
      PRDATA = {26'h0000000, avail};
    end else if (hit_rate) begin
      PRDATA = achieved;
    end else if (hit_oen) begin
      PRDATA = {31'h00000000, out_en};
    end else if (hit_ofreq) begin
      PRDATA = clkout_freq;
    end else if (hit_chan) begin
      PRDATA = {28'h0000000, chan};
    end
  end

  // Software registers
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      src_sel <= CODE_PLL;
      request <= RATE_RESET_HZ;
      out_en  <= 1'h0;
      chan    <= CH_RESET;
    end else if (CLK_EN && wr_done) begin
      if (hit_mode) begin
        src_sel <= PWDATA[5:0];
      end
      if (hit_rate) begin
        request <= PWDATA;
      end
      if (hit_oen) begin
        out_en <= PWDATA[0];
      end
      if (hit_chan) begin
        chan <= PWDATA[3:0] & (four_ch ? CH_ALL : CH_TWO);
      end
    end
  end

  // Any change of source, rate or channels reruns the calculation; a new event beats consumption
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      recalc <= 1'h1;
    end else if (CLK_EN) begin
      recalc <= (wr_done && (hit_mode || hit_rate || hit_chan)) || (recalc && !strap_taken);
    end
  end

  // Limits for the current board and channel set
  assign rmax = max_rate(fast, chan);
  always_comb begin
    clamped = request;
    if (request < RATE_MIN_HZ) begin
      clamped = RATE_MIN_HZ;
    end else if (request > rmax) begin
      clamped = rmax;
    end
  end

  // The first oscillator runs at the board maximum
  assign osc_hz   = (src_sel == CODE_Q2) ? SECOND_OSC_HZ : max_rate(fast, 4'h0);
  assign go       = recalc && strap_taken;
  assign too_fast = rate_q > rmax;
  assign too_slow = (rate_q < RATE_MIN_HZ) && (div_n > ONE32);

  // Divider operands; rounding divide picks the nearest ratio
  assign div.ce       = CLK_EN;
  assign div.start    = (state == ST_LAUNCH_N) || (state == ST_LAUNCH_R);
  assign div.dividend = (state == ST_LAUNCH_N) ? 32'(osc_hz + (clamped >> 1)) : osc_hz;
  assign div.divisor  = (state == ST_LAUNCH_N) ? clamped : div_n;

  cks_divider u_div (
    .clk   (CLK_SYS),
    .rst_n (rst_n),
    .port  (div.engine)
  );

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (CLK_EN) begin
      if (go) begin
        state <= is_quartz ? ST_LAUNCH_N : ST_IDLE;
      end else begin
        case (state)
          ST_LAUNCH_N: state <= ST_WAIT_N;
          ST_WAIT_N: begin
            if (div.done) begin
              state <= ST_LAUNCH_R;
            end
          end
          ST_LAUNCH_R: state <= ST_WAIT_R;
          ST_WAIT_R: begin
            if (div.done) begin
              state <= ST_CHECK;
            end
          end
          ST_CHECK: state <= (too_fast || too_slow) ? ST_LAUNCH_R : ST_IDLE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Working divider and rate; rounding can overshoot a limit by one step
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      div_n  <= ONE32;
      rate_q <= ZERO32;
    end else if (CLK_EN) begin
      if (state == ST_WAIT_N && div.done) begin
        div_n <= (div.quotient == ZERO32) ? ONE32 : div.quotient;
      end else if (state == ST_CHECK && too_fast) begin
        div_n <= 32'(div_n + ONE32);
      end else if (state == ST_CHECK && too_slow) begin
        div_n <= 32'(div_n - ONE32);
      end
      if (state == ST_WAIT_R && div.done) begin
        rate_q <= div.quotient;
      end
    end
  end

  // Committed result; the PLL path is treated as fine-grained
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      achieved <= RATE_RESET_HZ;
      divider  <= ONE32;
    end else if (CLK_EN) begin
      if (go) begin
        if (!is_quartz) begin
          achieved <= clamped;
          divider  <= ONE32;
        end
      end else if (state == ST_CHECK && !too_fast && !too_slow) begin
        achieved <= rate_q;
        divider  <= div_n;
      end
    end
  end

  // Connector drive only with an internal source
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CLKOUT_DRIVE <= 1'h0;
    end else if (CLK_EN) begin
      CLKOUT_DRIVE <= out_en && is_internal;
    end
  end

  assign SOURCE_SELECT  = src_sel;
  assign DIVIDER        = divider;
  assign RATE_HZ        = achieved;
  assign CHANNEL_ENABLE = chan;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence s_quartz_start;
    go && is_quartz && CLK_EN ##1 state == ST_LAUNCH_N;
  endsequence

  sequence s_clkout_write;
    wr_done && hit_oen && PWDATA[0] && is_internal ##1 CLK_EN;
  endsequence

  a_pll_default: assert property ($rose(rst_n) |-> src_sel == CODE_PLL)
    else $error("Reset did not leave the PLL selected");
  a_pll_write: assert property (wr_done && hit_mode && PWDATA[5:0] == CODE_PLL |=> src_sel == CODE_PLL)
    else $error("PLL code write not taken");
  a_q1_write: assert property (wr_done && hit_mode && PWDATA[5:0] == CODE_Q1 |=> src_sel == CODE_Q1)
    else $error("First oscillator code write not taken");
  a_q2_write: assert property (CLK_EN && hit_mode && PWRITE && PREADY && PWDATA[5:0] == CODE_Q2
                               && PWDATA[31:6] == 26'h0000000 |=> (src_sel == CODE_Q2) == q2_fitted)
    else $error("Second oscillator selection disagrees with fitting");
  a_avail_mask: assert property (strap_taken |-> avail[2] == q2_fitted && avail[1:0] == 2'h3)
    else $error("Available source mask wrong");
  a_rate_readback: assert property (PREADY && !PWRITE && hit_rate |-> PRDATA == RATE_HZ && state == ST_IDLE)
    else $error("Rate read while result unsettled");
  a_clkout_on: assert property (s_clkout_write |=> CLKOUT_DRIVE)
    else $error("Clock output not driven after enable");
  a_clkout_gate: assert property (CLKOUT_DRIVE && $past(CLK_EN)
                                  |-> ($past(src_sel) & CODE_INT_MASK) != CODE_NONE)
    else $error("Clock output driven from an external source");
  a_clkout_freq: assert property (PREADY && !PWRITE && hit_ofreq && !out_en |-> PRDATA == ZERO32)
    else $error("Output frequency nonzero while output off");
  a_rate_floor: assert property (state == ST_IDLE && !recalc |-> RATE_HZ >= RATE_MIN_HZ)
    else $error("Rate below minimum");
  a_rate_ceiling: assert property (state == ST_IDLE && !recalc && strap_taken |-> RATE_HZ <= rmax)
    else $error("Rate above board limit");
  a_slow_limit: assert property (strap_taken && !fast |-> rmax == SLOW_MAX_HZ && (four_ch || chan[3:2] == 2'h0))
    else $error("Slow board limit or channel mask wrong");
  a_q1_divide: assert property (state == ST_IDLE && !recalc && src_sel == CODE_Q1 && strap_taken
                                |-> DIVIDER != ZERO32 && RATE_HZ == osc_hz / DIVIDER)
    else $error("First oscillator rate is not a plain division");
  a_quartz_settle: assert property (s_quartz_start |-> ##[1:300] (state == ST_IDLE || !CLK_EN))
    else $error("Divider search did not settle");
  a_q2_divide: assert property (state == ST_IDLE && !recalc && src_sel == CODE_Q2
                                |-> RATE_HZ == SECOND_OSC_HZ / DIVIDER)
    else $error("Second oscillator rate is not a plain division");
  a_clkout_off: assert property (out_en && !is_internal && CLK_EN |=> !CLKOUT_DRIVE)
    else $error("Clock output active with external source");
endmodule
`default_nettype wire

// file: verif/testbench.sv
`default_nettype none
module testbench
  import cks_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [ADDR_W-1:0] A_RATE  = 19'h13880;
  localparam logic [ADDR_W-1:0] A_CHAN  = 19'h13888;
  localparam logic [ADDR_W-1:0] A_EN    = 19'h13a38;
  localparam logic [ADDR_W-1:0] A_FREQ  = 19'h13a3c;
  localparam logic [ADDR_W-1:0] A_SRC   = 19'h13ba0;
  localparam logic [ADDR_W-1:0] A_AVAIL = 19'h13ba4;
  localparam logic [ADDR_W-1:0] A_NONE  = 19'h00010;
  // Second oscillator frequency, arbitrary; odd enough that both divider corrections fire
  localparam logic [31:0]       OSC2_HZ = 32'h07271058;

  logic              clk_sys;
  logic              reset_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [5:0]        source_select;
  logic [31:0]       divider;
  logic [31:0]       rate_hz;
  logic [3:0]        channel_enable;
  logic              clkout_drive;
  logic              fast_strap;
  logic              four_strap;
  logic              q2_strap;
  int                failures;
  int                checked;

  always #2.5 clk_sys = ~clk_sys;

  // Straps are sampled once per reset, so each reset picks one board build
  cks_clock_select #(.SECOND_OSC_HZ(OSC2_HZ)) u_dut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(1'b1),
    .FAST_VARIANT(fast_strap), .FOUR_CHANNELS(four_strap), .SECOND_OSC_FITTED(q2_strap),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SOURCE_SELECT(source_select), .DIVIDER(divider), .RATE_HZ(rate_hz),
    .CHANNEL_ENABLE(channel_enable), .CLKOUT_DRIVE(clkout_drive)
  );

  task automatic complete_run;
    $display("Counts: checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Holds the request until PREADY is seen high, then releases it
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 1000);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      $display("ERROR at %0t: no bus answer", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] v;
    logic        e;
    apb(1'b1, a, d, v, e);
    chk_bit(e, exp_err, "write response");
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 32'h00000000, v, e);
    chk_bit(e, 1'b0, "read response");
    chk_word(v, exp, "read data");
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // Nearest divider for an already clamped request, stepped once back into range; divider in the upper word
  function automatic logic [63:0] exp_osc(input logic [31:0] f, input logic [31:0] req, input logic [31:0] lim);
    longint n;
    n = (longint'(f) + longint'(req) / 2) / longint'(req);
    if (n == 0) begin
      n = 1;
    end
    if (longint'(f) / n > longint'(lim)) begin
      n = n + 1;
    end else if (longint'(f) / n < longint'(RATE_MIN_HZ) && n > 1) begin
      n = n - 1;
    end
    return {32'(n), 32'(longint'(f) / n)};
  endfunction

  task automatic pll_case(input logic [31:0] req, input logic [31:0] exp);
    wr(A_RATE, req, 1'b0);
    rd_chk(A_RATE, exp);
    #1;
    chk_word(divider, 32'h00000001, "pll divider");
  endtask

  task automatic osc_case(input logic [31:0] f, input logic [31:0] req, input logic [31:0] clamped,
                          input logic [31:0] lim);
    logic [63:0] e;
    e = exp_osc(f, clamped, lim);
    wr(A_RATE, req, 1'b0);
    rd_chk(A_RATE, e[31:0]);
    #1;
    chk_word(divider, e[63:32], "divider");
    chk_word(rate_hz, e[31:0], "committed rate");
  endtask

  task automatic t_defaults(input logic [31:0] exp_avail);
    rd_chk(A_SRC, {26'h0000000, CODE_PLL});
    rd_chk(A_RATE, RATE_RESET_HZ);
    rd_chk(A_AVAIL, exp_avail);
    rd_chk(A_EN, 32'h00000000);
    rd_chk(A_FREQ, 32'h00000000);
    settle();
    chk_word({26'h0000000, source_select}, {26'h0000000, CODE_PLL}, "source out");
    chk_word(divider, 32'h00000001, "reset divider");
    chk_bit(clkout_drive, 1'b0, "reset drive");
    $display("test defaults done");
  endtask

  task automatic t_pll;
    wr(A_SRC, {26'h0000000, CODE_PLL}, 1'b0);
    pll_case(32'h00bc614e, 32'h00bc614e);
    pll_case(32'h000001f4, 32'h000003e8);
    pll_case(32'h11e1a300, 32'h0bebc200);
    wr(A_CHAN, 32'h00000005, 1'b0);
    rd_chk(A_RATE, 32'h0bebc200);
    wr(A_CHAN, 32'h00000002, 1'b0);
    rd_chk(A_RATE, 32'h05f5e100);
    wr(A_CHAN, 32'h00000008, 1'b0);
    rd_chk(A_RATE, 32'h05f5e100);
    wr(A_CHAN, 32'h00000001, 1'b0);
    $display("test pll done");
  endtask

  task automatic t_osc1;
    wr(A_SRC, {26'h0000000, CODE_Q1}, 1'b0);
    osc_case(32'h0bebc200, 32'h03938700, 32'h03938700, 32'h0bebc200);
    osc_case(32'h0bebc200, 32'h11e1a300, 32'h0bebc200, 32'h0bebc200);
    osc_case(32'h0bebc200, 32'h000003e8, 32'h000003e8, 32'h0bebc200);
    osc_case(32'h0bebc200, 32'h00000001, 32'h000003e8, 32'h0bebc200);
    chk_word({26'h0000000, source_select}, {26'h0000000, CODE_Q1}, "source out");
    $display("test first oscillator done");
  endtask

  task automatic t_osc2;
    wr(A_SRC, {26'h0000000, CODE_Q2}, 1'b0);
    osc_case(OSC2_HZ, 32'h01c9c380, 32'h01c9c380, 32'h0bebc200);
    osc_case(OSC2_HZ, OSC2_HZ, OSC2_HZ, 32'h0bebc200);
    osc_case(OSC2_HZ, 32'h11e1a300, 32'h0bebc200, 32'h0bebc200);
    osc_case(OSC2_HZ, 32'h000003e8, 32'h000003e8, 32'h0bebc200);
    wr(A_CHAN, 32'h00000002, 1'b0);
    osc_case(OSC2_HZ, 32'h05f5e100, 32'h05f5e100, 32'h05f5e100);
    wr(A_CHAN, 32'h00000001, 1'b0);
    $display("test second oscillator done");
  endtask

  task automatic t_clkout;
    wr(A_SRC, {26'h0000000, CODE_PLL}, 1'b0);
    wr(A_RATE, 32'h017d7840, 1'b0);
    wr(A_EN, 32'h00000001, 1'b0);
    rd_chk(A_EN, 32'h00000001);
    rd_chk(A_FREQ, 32'h017d7840);
    settle();
    chk_bit(clkout_drive, 1'b1, "drive with pll");
    wr(A_SRC, 32'h00000008, 1'b0);
    rd_chk(A_FREQ, 32'h00000000);
    settle();
    chk_bit(clkout_drive, 1'b0, "drive with external");
    wr(A_SRC, {26'h0000000, CODE_Q1}, 1'b0);
    rd_chk(A_FREQ, 32'h017d7840);
    settle();
    chk_bit(clkout_drive, 1'b1, "drive with oscillator");
    wr(A_EN, 32'h00000000, 1'b0);
    settle();
    chk_bit(clkout_drive, 1'b0, "drive disabled");
    $display("test clock output done");
  endtask

  task automatic t_refuse;
    logic [31:0] v;
    logic        e;
    wr(A_SRC, 32'h00000003, 1'b1);
    wr(A_SRC, 32'h00000040, 1'b1);
    rd_chk(A_SRC, {26'h0000000, CODE_Q1});
    wr(A_AVAIL, 32'h00000000, 1'b1);
    rd_chk(A_AVAIL, 32'h0000003f);
    wr(A_FREQ, 32'h00000000, 1'b1);
    apb(1'b0, A_NONE, 32'h00000000, v, e);
    chk_bit(e, 1'b1, "unmapped response");
    chk_word(v, 32'h00000000, "unmapped data");
    $display("test refusals done");
  endtask

  task automatic t_slow;
    wr(A_SRC, {26'h0000000, CODE_Q2}, 1'b1);
    rd_chk(A_SRC, {26'h0000000, CODE_PLL});
    wr(A_CHAN, 32'h0000000f, 1'b0);
    rd_chk(A_CHAN, 32'h00000003);
    #1;
    chk_word({28'h0000000, channel_enable}, 32'h00000003, "channel out");
    pll_case(32'h11e1a300, 32'h02faf080);
    wr(A_SRC, {26'h0000000, CODE_Q1}, 1'b0);
    osc_case(32'h02faf080, 32'h01312d00, 32'h01312d00, 32'h02faf080);
    $display("test slow board done");
  endtask

  initial begin
    clk_sys  = 1'b0;
    reset_n  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = '0;
    pwdata     = 32'h00000000;
    fast_strap = 1'b1;
    four_strap = 1'b1;
    q2_strap   = 1'b1;
    failures = 0;
    checked  = 0;
    do_reset();
    t_defaults(32'h0000003f);
    t_pll();
    t_osc1();
    t_osc2();
    t_clkout();
    t_refuse();
    // Reset again in mid-run as a slow two-channel board without the second oscillator
    @(posedge clk_sys);
    fast_strap <= 1'b0;
    four_strap <= 1'b0;
    q2_strap   <= 1'b0;
    do_reset();
    t_defaults(32'h0000003b);
    t_slow();
    complete_run();
  end
endmodule
`default_nettype wire
